/* File: rtl/incr_or_shift_branch_exec.sv */
// execute stage for step, or, shift and far-jump instructions
`timescale 1ns/1ps
`include "incr_or_shift_branch_exec_cfg.svh"

// Function
// - a destination bit of 0 sends the result to the accumulator, 1 back to the file register.
// - the file operand is a 7-bit address 0..127 and the destination a single bit.
// - step-and-skip adds one, writes the destination, keeps flags, and a zero result turns the next slot idle.
// - the far jump loads its 11-bit immediate into program counter bits 10..0.
// - the far jump fills program counter bits 14..11 from upper latch bits 6..3.
// - the far jump takes two cycles and touches no flag.
// - or-literal ors the accumulator with an 8-bit immediate into the accumulator and updates zero.
// - plain step adds one, writes the chosen destination and updates zero, with no skip.
// - or-file ors the accumulator with the file register into the chosen destination and updates zero.
// - left shift moves file bit 7 to carry, bits 6..0 up one, zero into bit 0, updating carry and zero.
module incr_or_shift_branch_exec #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7,
    parameter int PC_W   = 15,
    parameter int JUMP_W = 11
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // instruction in
    input  wire logic                   instr_valid,
    input  wire logic [`IOSB_WORD_W-1:0] instr_word,
    // operands
    input  wire logic [DATA_W-1:0]      acc_val,
    input  wire logic [DATA_W-1:0]      file_val,
    input  wire logic [6:0]             upper_pc_latch,
    // accumulator write
    output logic                        acc_we_q,
    output logic [DATA_W-1:0]           acc_wd_q,
    // file register write
    output logic                        file_we_q,
    output logic [ADDR_W-1:0]           file_addr_q,
    output logic [DATA_W-1:0]           file_wd_q,
    // flags
    output logic                        zero_we_q,
    output logic                        zero_q,
    output logic                        carry_we_q,
    output logic                        carry_q,
    // program counter
    output logic                        pc_load_q,
    output logic [PC_W-1:0]             pc_next_q,
    // sequencing
    output logic                        skip_q,
    output logic                        idle_slot_q,
    output logic                        unknown_q
);

    // ----------------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------------
    incr_or_shift_branch_exec_pkg::op_t    op;
    incr_or_shift_branch_exec_pkg::state_t state_q;
    incr_or_shift_branch_exec_pkg::state_t state_d;

    logic [5:0]        opc6;
    logic [2:0]        opc3;
    logic              dest_sel;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] literal;
    logic [JUMP_W-1:0] jump_tgt;
    logic              take;

    assign opc6      = instr_word[`IOSB_OP6_MSB:`IOSB_OP6_LSB];
    assign opc3      = instr_word[`IOSB_OP3_MSB:`IOSB_OP3_LSB];
    assign dest_sel  = instr_word[`IOSB_DEST_BIT];
    assign file_addr = instr_word[`IOSB_FILE_MSB:0];
    assign literal   = instr_word[`IOSB_LIT_MSB:0];
    assign jump_tgt  = instr_word[`IOSB_JUMP_MSB:0];

    // the slot after a jump or taken skip holds an already fetched word
    assign take = instr_valid
                  && (state_q == incr_or_shift_branch_exec_pkg::st_exec);

    always_comb
    begin
        op = incr_or_shift_branch_exec_pkg::op_none;
        if (opc3 == `IOSB_OPC_JUMP)
        begin
            op = incr_or_shift_branch_exec_pkg::op_jump_far;
        end
        else
        begin
            case (opc6)
                `IOSB_OPC_STEP_SKIP:
                    op = incr_or_shift_branch_exec_pkg::op_step_up_skip_if_null;
                `IOSB_OPC_STEP_FILE:
                    op = incr_or_shift_branch_exec_pkg::op_step_up_file;
                `IOSB_OPC_OR_FILE:
                    op = incr_or_shift_branch_exec_pkg::op_or_acc_into_file;
                `IOSB_OPC_SHIFT_L:
                    op = incr_or_shift_branch_exec_pkg::op_shift_left_file;
                `IOSB_OPC_OR_LIT:
                    op = incr_or_shift_branch_exec_pkg::op_or_literal_into_acc;
                default:
                    op = incr_or_shift_branch_exec_pkg::op_none;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------------
    logic [DATA_W-1:0] result;
    logic              res_to_file;
    logic              res_to_acc;
    logic              upd_zero;
    logic              upd_carry;
    logic              carry_new;
    logic              jump;
    logic              skip;

    always_comb
    begin
        result    = `IOSB_RST_DATA;
        upd_zero  = 1'b0;
        upd_carry = 1'b0;
        carry_new = 1'b0;
        jump      = 1'b0;
        skip      = 1'b0;
        case (op)
            incr_or_shift_branch_exec_pkg::op_step_up_skip_if_null:
            begin
                result = DATA_W'(file_val + 1'b1);
                skip   = (result == '0);
            end
            incr_or_shift_branch_exec_pkg::op_step_up_file:
            begin
                result   = DATA_W'(file_val + 1'b1);
                upd_zero = 1'b1;
            end
            incr_or_shift_branch_exec_pkg::op_or_acc_into_file:
            begin
                result   = acc_val | file_val;
                upd_zero = 1'b1;
            end
            incr_or_shift_branch_exec_pkg::op_or_literal_into_acc:
            begin
                result   = acc_val | literal;
                upd_zero = 1'b1;
            end
            incr_or_shift_branch_exec_pkg::op_shift_left_file:
            begin
                result    = {file_val[DATA_W-2:0], 1'b0};
                carry_new = file_val[DATA_W-1];
                upd_carry = 1'b1;
                upd_zero  = 1'b1;
            end
            incr_or_shift_branch_exec_pkg::op_jump_far:
            begin
                jump = 1'b1;
            end
            default:
            begin
                result = `IOSB_RST_DATA;
            end
        endcase
    end

    // or-literal always lands in the accumulator; jump writes no data
    always_comb
    begin
        res_to_file = 1'b0;
        res_to_acc  = 1'b0;
        case (op)
            incr_or_shift_branch_exec_pkg::op_step_up_skip_if_null,
            incr_or_shift_branch_exec_pkg::op_step_up_file,
            incr_or_shift_branch_exec_pkg::op_or_acc_into_file,
            incr_or_shift_branch_exec_pkg::op_shift_left_file:
            begin
                res_to_file = (dest_sel == `IOSB_DEST_FILE);
                res_to_acc  = (dest_sel == `IOSB_DEST_ACC);
            end
            incr_or_shift_branch_exec_pkg::op_or_literal_into_acc:
            begin
                res_to_acc = 1'b1;
            end
            default:
            begin
                res_to_acc = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------------
    always_comb
    begin
        case (state_q)
            incr_or_shift_branch_exec_pkg::st_exec:
            begin
                if (take && (jump || skip))
                    state_d = incr_or_shift_branch_exec_pkg::st_idle_slot;
                else
                    state_d = incr_or_shift_branch_exec_pkg::st_exec;
            end
            incr_or_shift_branch_exec_pkg::st_idle_slot:
                state_d = incr_or_shift_branch_exec_pkg::st_exec;
            default:
                state_d = incr_or_shift_branch_exec_pkg::st_exec;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_q <= incr_or_shift_branch_exec_pkg::st_exec;
        else
            state_q <= state_d;
    end

    // one idle cycle replaces the word fetched behind a jump or taken skip
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            idle_slot_q <= 1'b0;
            skip_q      <= 1'b0;
        end
        else
        begin
            idle_slot_q <= (state_q == incr_or_shift_branch_exec_pkg::st_idle_slot);
            skip_q      <= take && skip;
        end
    end

    // ----------------------------------------------------------------------
    // result writes
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            acc_we_q    <= 1'b0;
            acc_wd_q    <= `IOSB_RST_DATA;
            file_we_q   <= 1'b0;
            file_addr_q <= `IOSB_RST_ADDR;
            file_wd_q   <= `IOSB_RST_DATA;
        end
        else
        begin
            acc_we_q  <= take && res_to_acc;
            file_we_q <= take && res_to_file;
            if (take)
            begin
                acc_wd_q    <= result;
                file_addr_q <= file_addr;
                file_wd_q   <= result;
            end
        end
    end

    // ----------------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            zero_we_q  <= 1'b0;
            zero_q     <= 1'b0;
            carry_we_q <= 1'b0;
            carry_q    <= 1'b0;
        end
        else
        begin
            zero_we_q  <= take && upd_zero;
            carry_we_q <= take && upd_carry;
            if (take && upd_zero)
                zero_q <= (result == '0);
            if (take && upd_carry)
                carry_q <= carry_new;
        end
    end

    // ----------------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pc_load_q <= 1'b0;
            pc_next_q <= `IOSB_RST_PC;
            unknown_q <= 1'b0;
        end
        else
        begin
            pc_load_q <= take && jump;
            unknown_q <= take && (op == incr_or_shift_branch_exec_pkg::op_none);
            if (take && jump)
                pc_next_q <= {upper_pc_latch[`IOSB_LATCH_MSB:`IOSB_LATCH_LSB],
                              jump_tgt};
        end
    end

endmodule : incr_or_shift_branch_exec

/* File: rtl/incr_or_shift_branch_exec_cfg.svh */
// field positions, opcode patterns and reset values of the execute block
`ifndef INCR_OR_SHIFT_BRANCH_EXEC_CFG_SVH
`define INCR_OR_SHIFT_BRANCH_EXEC_CFG_SVH

// --------------------------------------------------------------------------
// instruction word fields
// --------------------------------------------------------------------------
`define IOSB_WORD_W        14
`define IOSB_OP6_MSB       13
`define IOSB_OP6_LSB       8
`define IOSB_OP3_MSB       13
`define IOSB_OP3_LSB       11
`define IOSB_DEST_BIT      7
`define IOSB_FILE_MSB      6
`define IOSB_LIT_MSB       7
`define IOSB_JUMP_MSB      10
`define IOSB_LATCH_MSB     6
`define IOSB_LATCH_LSB     3

// --------------------------------------------------------------------------
// opcode patterns
// --------------------------------------------------------------------------
`define IOSB_OPC_STEP_SKIP 6'h0f
`define IOSB_OPC_STEP_FILE 6'h0a
`define IOSB_OPC_OR_FILE   6'h04
`define IOSB_OPC_SHIFT_L   6'h35
`define IOSB_OPC_OR_LIT    6'h38
`define IOSB_OPC_JUMP      3'h5

// --------------------------------------------------------------------------
// destination select and reset values
// --------------------------------------------------------------------------
`define IOSB_DEST_ACC      1'h0
`define IOSB_DEST_FILE     1'h1
`define IOSB_RST_DATA      8'h00
`define IOSB_RST_ADDR      7'h00
`define IOSB_RST_PC        15'h0000

`endif

/* File: rtl/incr_or_shift_branch_exec_pkg.sv */
// types shared by the execute block
package incr_or_shift_branch_exec_pkg;

    typedef enum {
        op_none,
        op_step_up_skip_if_null,
        op_jump_far,
        op_or_literal_into_acc,
        op_step_up_file,
        op_or_acc_into_file,
        op_shift_left_file
    } op_t;

    typedef enum {
        st_exec,
        st_idle_slot
    } state_t;

endpackage : incr_or_shift_branch_exec_pkg

/* File: test/incr_or_shift_branch_exec_properties.sv */
// concurrent checks on the ports of the execute block
`timescale 1ns/1ps
module incr_or_shift_branch_exec_properties (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // instruction and operands
    input wire logic        instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0]  acc_val,
    input wire logic [7:0]  file_val,
    input wire logic [6:0]  upper_pc_latch,
    // results
    input wire logic        acc_we_q,
    input wire logic [7:0]  acc_wd_q,
    input wire logic        file_we_q,
    input wire logic [6:0]  file_addr_q,
    input wire logic [7:0]  file_wd_q,
    input wire logic        zero_we_q,
    input wire logic        zero_q,
    input wire logic        carry_we_q,
    input wire logic        carry_q,
    input wire logic        pc_load_q,
    input wire logic [14:0] pc_next_q,
    input wire logic        skip_q,
    input wire logic        idle_slot_q
);
    // ----------------------------------------------------------------------
    // shadow of the word taken at the last edge
    // ----------------------------------------------------------------------
    logic        tk_q;
    logic [13:0] w_q;
    logic [7:0]  a_q;
    logic [7:0]  f_q;
    logic [6:0]  l_q;
    logic [7:0]  res;
    logic        byte_op;
    wire  [5:0]  op  = w_q[13:8];
    wire         jmp = tk_q && w_q[13:11] == 3'h5;

    // the word seen while a skip or jump pulse stands is dropped
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            {tk_q, w_q, a_q, f_q, l_q} <= '0;
        else
        begin
            tk_q <= instr_valid && !skip_q && !pc_load_q;
            {w_q, a_q, f_q, l_q} <= {instr_word, acc_val, file_val,
                                     upper_pc_latch};
        end
    end

    always_comb
    begin
        byte_op = 1'h1;
        case (op)
            6'h0f, 6'h0a: res = f_q + 8'h01;
            6'h04:        res = a_q | f_q;
            6'h35:        res = {f_q[6:0], 1'h0};
            default:
            begin
                byte_op = 1'h0;
                res     = a_q | w_q[7:0];
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    dest_select_a : assert property (
        tk_q && byte_op |-> file_we_q == w_q[7] && acc_we_q == !w_q[7]
            && file_addr_q == w_q[6:0]) else $error("wrong destination");
    result_value_a : assert property (
        tk_q && byte_op |-> (w_q[7] ? file_wd_q : acc_wd_q) == res)
        else $error("wrong result value");
    zero_flag_a : assert property (
        tk_q && byte_op && op != 6'h0f |-> zero_we_q
            && zero_q == (res == 8'h00))
        else $error("wrong zero flag");
    skip_result_a : assert property (
        tk_q && op == 6'h0f |-> !zero_we_q && !carry_we_q
            && skip_q == (res == 8'h00)) else $error("wrong skip");
    no_skip_a : assert property (
        tk_q && op != 6'h0f |-> !skip_q) else $error("skip without cause");
    or_literal_a : assert property (
        tk_q && op == 6'h38 |-> acc_we_q && !file_we_q && acc_wd_q == res
            && zero_we_q && zero_q == (res == 8'h00))
        else $error("wrong or literal");
    jump_target_a : assert property (
        jmp |-> pc_load_q && pc_next_q == {l_q[6:3], w_q[10:0]})
        else $error("wrong jump target");
    jump_quiet_a : assert property (
        jmp |-> !zero_we_q && !carry_we_q && !acc_we_q && !file_we_q)
        else $error("jump touched state");
    shift_carry_a : assert property (
        tk_q && op == 6'h35 |-> carry_we_q && carry_q == f_q[7])
        else $error("wrong carry");
    idle_slot_a : assert property (
        skip_q || pc_load_q |=> idle_slot_q && !acc_we_q && !file_we_q
            && !pc_load_q && !skip_q ##1 !idle_slot_q)
        else $error("missing idle slot");
    idle_cause_a : assert property (
        idle_slot_q |-> $past(skip_q) || $past(pc_load_q))
        else $error("idle slot without cause");
endmodule : incr_or_shift_branch_exec_properties

bind incr_or_shift_branch_exec incr_or_shift_branch_exec_properties
    incr_or_shift_branch_exec_properties_i (
    .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .acc_val(acc_val), .file_val(file_val),
    .upper_pc_latch(upper_pc_latch), .acc_we_q(acc_we_q),
    .acc_wd_q(acc_wd_q), .file_we_q(file_we_q), .file_addr_q(file_addr_q),
    .file_wd_q(file_wd_q), .zero_we_q(zero_we_q), .zero_q(zero_q),
    .carry_we_q(carry_we_q), .carry_q(carry_q), .pc_load_q(pc_load_q),
    .pc_next_q(pc_next_q), .skip_q(skip_q), .idle_slot_q(idle_slot_q));

/* File: test/incr_or_shift_branch_exec_tb.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
module incr_or_shift_branch_exec_tb;
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic        instr_valid = 1'h0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0]  acc_val = 8'h00;
    logic [7:0]  file_val = 8'h00;
    logic [6:0]  upper_pc_latch = 7'h00;
    logic        acc_we_q, file_we_q, zero_we_q, zero_q, carry_we_q, carry_q;
    logic        pc_load_q, skip_q, idle_slot_q, unknown_q;
    logic [7:0]  acc_wd_q, file_wd_q, r, ta, tf;
    logic [6:0]  file_addr_q, tl;
    logic [14:0] pc_next_q;
    logic [10:0] jk;
    logic        d;
    logic [5:0]  opc [3] = '{6'h0a, 6'h04, 6'h35};
    logic [7:0]  fv [4] = '{8'hff, 8'h00, 8'h80, 8'h5a};
    int          n_errors = 0;
    int          samples_checked = 0;

    always #12.5 clk_sys = ~clk_sys;

    incr_or_shift_branch_exec incr_or_shift_branch_exec_i (
        .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .acc_val(acc_val), .file_val(file_val),
        .upper_pc_latch(upper_pc_latch), .acc_we_q(acc_we_q),
        .acc_wd_q(acc_wd_q), .file_we_q(file_we_q),
        .file_addr_q(file_addr_q), .file_wd_q(file_wd_q),
        .zero_we_q(zero_we_q), .zero_q(zero_q), .carry_we_q(carry_we_q),
        .carry_q(carry_q), .pc_load_q(pc_load_q), .pc_next_q(pc_next_q),
        .skip_q(skip_q), .idle_slot_q(idle_slot_q), .unknown_q(unknown_q));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // called at a falling edge; the word stands for exactly one cycle
    task put(input logic [13:0] w, input logic [7:0] a, input logic [7:0] f,
             input logic [6:0] l);
        instr_valid    = 1'h1;
        instr_word     = w;
        acc_val        = a;
        file_val       = f;
        upper_pc_latch = l;
        @(negedge clk_sys);
    endtask : put

    task test_done;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (2000) @(posedge clk_sys);
        n_errors++;
        $display("ERROR %0t: run did not finish", $time);
        test_done();
    end

    initial
    begin
        repeat (6) @(negedge clk_sys);
        rst = 1'h0;
        // byte ops, both destinations, back to back
        for (int i = 0; i < 3; i++)
            for (int j = 0; j < 8; j++)
            begin
                d  = j[0];
                ta = j[2] ? 8'h21 : 8'h00;
                tf = fv[j[2:1]];
                r  = i == 0 ? tf + 8'h01 : i == 1 ? ta | tf : {tf[6:0], 1'h0};
                put({opc[i], d, d ? 7'h7f : 7'h00}, ta, tf, 7'h00);
                chk({file_we_q, acc_we_q}, {d, !d});
                chk(d ? file_wd_q : acc_wd_q, r);
                chk(file_addr_q, d ? 7'h7f : 7'h00);
                chk({zero_we_q, zero_q}, {1'h1, r == 8'h00});
                chk(carry_we_q, i == 2);
                if (i == 2)
                    chk(carry_q, tf[7]);
            end
        // literal with its top bit set must not act as a destination bit
        for (int j = 0; j < 2; j++)
        begin
            ta = j ? 8'h0f : 8'h00;
            r  = ta | (j ? 8'hf0 : 8'h00);
            put({6'h38, j ? 8'hf0 : 8'h00}, ta, 8'h33, 7'h00);
            chk({acc_we_q, file_we_q, acc_wd_q}, {2'h2, r});
            chk({zero_we_q, zero_q}, {1'h1, r == 8'h00});
        end
        // step-and-skip, then a follower that is dropped only on a skip
        for (int j = 0; j < 4; j++)
        begin
            d  = j[0];
            tf = j[1] ? 8'hff : 8'hfe;
            r  = tf + 8'h01;
            put({6'h0f, d, 7'h15}, 8'h00, tf, 7'h00);
            chk(d ? file_wd_q : acc_wd_q, r);
            chk({file_we_q, acc_we_q}, {d, !d});
            chk({skip_q, zero_we_q, carry_we_q}, {j[1], 2'h0});
            put(14'h0a05, 8'h00, 8'h10, 7'h00);
            chk({idle_slot_q, acc_we_q}, {j[1], !j[1]});
        end
        // far jumps; latch values tell bits 6..3 apart from 4..3
        for (int j = 0; j < 2; j++)
        begin
            tl = j ? 7'h60 : 7'h1f;
            jk = j ? 11'h7ff : 11'h000;
            put({3'h5, jk}, 8'h55, 8'haa, tl);
            chk(pc_load_q, 1'h1);
            chk(pc_next_q, {tl[6:3], jk});
            chk({acc_we_q, file_we_q}, 2'h0);
            chk({zero_we_q, carry_we_q}, 2'h0);
            put({6'h35, 1'h0, 7'h01}, 8'h00, 8'h81, 7'h00);
            chk(idle_slot_q, 1'h1);
            chk({acc_we_q, carry_we_q, pc_load_q}, 3'h0);
        end
        // a word outside the six decodes to nothing but its own pulse
        put(14'h0000, 8'h00, 8'h00, 7'h00);
        chk(unknown_q, 1'h1);
        chk({acc_we_q, file_we_q, pc_load_q}, 3'h0);
        chk({zero_we_q, carry_we_q, skip_q}, 3'h0);
        put(14'h0a05, 8'h00, 8'h10, 7'h00);
        chk({unknown_q, acc_we_q}, 2'h1);
        instr_valid = 1'h0;
        @(negedge clk_sys);
        test_done();
    end
endmodule : incr_or_shift_branch_exec_tb
